// ==== pkg/tx_desc_pkg.sv ====
// Constants and types shared by the transmit data descriptor decoder
package tx_desc_pkg;
   // Second-word field positions
   localparam int LEN_LSB = 0;
   localparam int LEN_W = 20;
   localparam int TYPE_LSB = 20;
   localparam int TYPE_W = 4;
   localparam int CMD_LSB = 24;
   localparam int EXT_LSB = 36;
   localparam int OPT_LSB = 40;
   localparam int TAG_LSB = 48;
   // Command byte bits
   localparam int CMD_DELAY = 7;
   localparam int CMD_TAG = 6;
   localparam int CMD_EXTF = 5;
   localparam int CMD_REPORT = 3;
   localparam int CMD_SEG = 2;
   localparam int CMD_CRC = 1;
   localparam int CMD_LAST = 0;
   // Extended command and option bits
   localparam int EXT_STAMP = 0;
   localparam int OPT_L4 = 1;
   localparam int OPT_L3 = 0;
   // Tag field layout
   localparam int TAG_PRI_LSB = 13;
   localparam int TAG_CFI = 12;
   localparam int TAG_ID_W = 12;
   // Descriptor type codes
   localparam logic [3:0] TYPE_DATA = 4'h1;
   localparam logic [3:0] TYPE_CTX = 4'h0;
   // Status nibble
   localparam logic [2:0] STATUS_RSV = 3'h0;
   // Delay timer unit and derived cycles at 250 MHz
   localparam int DELAY_UNIT_NS = 1024;
   localparam int CLK_PERIOD_NS = 4;
   localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;
   // Decoder states, Gray along the normal path
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_FINISH = 2'b11,
      ST_WRBK = 2'b10
   } dec_state_e;
endpackage

// ==== pkg/delay_timer_if.sv ====
// Link between the decoder and its interrupt delay timer
`timescale 1ns/1ns
interface delay_timer_if #(parameter int W = 16);
   logic load;        // Reload countdown from value
   logic clear;       // Stop and zero the countdown
   logic [W-1:0] value; // Delay in timer units
   logic expire;      // One-cycle pulse at count zero
   modport ctrl (output load, output clear, output value, input expire);
   modport timer (input load, input clear, input value, output expire);
endinterface

// ==== src/irq_delay_timer.sv ====
// Transmit interrupt delay countdown in units of the delay tick
`timescale 1ns/1ns
module irq_delay_timer
   import tx_desc_pkg::*;
#(
   parameter int W = 16,
   parameter int TICK_CYC = DELAY_UNIT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   delay_timer_if.timer tif
);
   typedef struct packed {
      logic [W-1:0] count; // Remaining units
      logic [15:0] pre;    // Cycles to next unit
      logic expire;        // Expiry pulse
   } timer_s;

   timer_s s;
   timer_s next_s;

   ////////////////////////////////////////////////////////////////////
   // Countdown: load restarts even if already running
   always_comb begin
      next_s = s;
      next_s.expire = 1'b0;
      if (tif.clear) begin
         next_s.count = '0;
         next_s.pre = '0;
      end else if (tif.load) begin
         next_s.count = tif.value;
         next_s.pre = 16'(TICK_CYC - 1);
      end else if (s.count != '0) begin
         if (s.pre == '0) begin
            // One unit elapsed
            next_s.pre = 16'(TICK_CYC - 1);
            next_s.count = s.count - 1'b1;
            next_s.expire = (s.count == W'(1));
         end else begin
            next_s.pre = s.pre - 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tif.expire = s.expire;
endmodule

// ==== src/tx_data_descriptor_decoder.sv ====
// Transmit extended data descriptor decoder with fetch and write-back
`timescale 1ns/1ns
module tx_data_descriptor_decoder
   import tx_desc_pkg::*;
#(
   parameter int DW = 16,             // Delay value width
   parameter int TICK_CYC = DELAY_UNIT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic desc_valid_i,
   input wire logic [63:0] desc_addr_i,
   input wire logic [63:0] desc_info_i,
   output logic desc_ready_o,
   output logic fetch_req_o,
   output logic [63:0] fetch_addr_o,
   output logic [LEN_W-1:0] fetch_len_o,
   output logic fetch_seg_o,
   input wire logic fetch_done_i,
   output logic wb_req_o,
   output logic [3:0] wb_status_o,
   input wire logic wb_ack_i,
   input wire logic wb_burst_en_i,
   input wire logic [DW-1:0] delay_value_field_i,
   input wire logic writeback_irq_cause_i,
   input wire logic [15:0] tag_ethertype_register_i,
   output logic tx_irq_o,
   output logic pkt_done_o,
   output logic pkt_tag_insert_o,
   output logic pkt_crc_append_o,
   output logic [15:0] pkt_tag_ethertype_o,
   output logic [2:0] pkt_priority_field_o,
   output logic pkt_canonical_format_flag_o,
   output logic [TAG_ID_W-1:0] pkt_tag_id_o,
   output logic pkt_l4_checksum_insert_o,
   output logic pkt_l3_checksum_insert_o,
   output logic pkt_capture_transmit_time_o,
   output logic pkt_segmented_o,
   output logic ctx_desc_o,
   output logic bad_desc_o
);
   ////////////////////////////////////////////////////////////////////
   // Whole state of the decoder
   typedef struct packed {
      dec_state_e state;
      logic ready;              // Descriptor input ready
      logic f_req;              // Data fetch request level
      logic [63:0] f_addr;      // Buffer address
      logic [LEN_W-1:0] f_len;  // Buffer byte length
      logic f_seg;              // Segmentation context member
      logic wb_req;             // Write-back request level
      logic [3:0] wb_status;    // Status nibble written back
      logic irq;                // Interrupt pulse
      logic t_load;             // Timer reload pulse
      logic t_clear;            // Timer clear pulse
      logic [7:0] cmd;          // Command byte of current descriptor
      logic in_pkt;             // Packet in progress
      logic lat_seg;            // Packet uses segmentation
      logic lat_tag;            // Sampled tag insert flag
      logic lat_crc;            // Sampled FCS insert flag
      logic [15:0] lat_vtag;    // Sampled tag field
      logic lat_l4;             // Option: L4 checksum
      logic lat_l3;             // Option: L3 checksum
      logic lat_ts;             // Capture_transmit_time request
      logic p_done;             // Packet end pulse
      logic p_tag;
      logic p_crc;
      logic [15:0] p_etype;
      logic [15:0] p_vtag;
      logic p_l4;
      logic p_l3;
      logic p_ts;
      logic p_seg;
      logic ctx;                // Context descriptor pulse
      logic bad;                // Unknown descriptor pulse
   } dec_s;

   dec_s s;
   dec_s next_s;

   // Decoded fields of the incoming descriptor
   logic [7:0] in_cmd;
   logic [3:0] in_type;
   logic [LEN_W-1:0] in_len;
   logic [7:0] in_opt;
   logic [3:0] in_ext;
   logic [15:0] in_vtag;
   logic take;

   delay_timer_if #(.W(DW)) tif ();

   ////////////////////////////////////////////////////////////////////
   // Field extraction from the second word
   assign in_len = desc_info_i[LEN_LSB +: LEN_W];
   assign in_type = desc_info_i[TYPE_LSB +: TYPE_W];
   assign in_cmd = desc_info_i[CMD_LSB +: 8];
   assign in_ext = desc_info_i[EXT_LSB +: 4];
   assign in_opt = desc_info_i[OPT_LSB +: 8];
   assign in_vtag = desc_info_i[TAG_LSB +: 16];
   assign take = desc_valid_i && s.ready;

   // Bit test on a command byte
   function automatic logic cmd_bit(input logic [7:0] c, input int b);
      cmd_bit = c[b];
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic first;
      logic seg;
      first = 1'b0;
      seg = 1'b0;
      next_s = s;
      // Pulses default low
      next_s.irq = 1'b0;
      next_s.t_load = 1'b0;
      next_s.t_clear = 1'b0;
      next_s.p_done = 1'b0;
      next_s.ctx = 1'b0;
      next_s.bad = 1'b0;
      // Delayed interrupt on countdown expiry
      if (tif.expire && writeback_irq_cause_i) begin
         next_s.irq = 1'b1;
      end
      case (s.state)
         ST_IDLE: begin
            // Raise ready on the first edge after reset, so the first descriptor can be taken
            if (!s.ready) begin
               next_s.ready = 1'b1;
            end
            if (take) begin
               if (cmd_bit(in_cmd, CMD_EXTF) && in_type == TYPE_DATA) begin
                  // Reserved command and option bits never read
                  next_s.ready = 1'b0;
                  next_s.cmd = in_cmd;
                  first = !s.in_pkt;
                  seg = first ? cmd_bit(in_cmd, CMD_SEG) : s.lat_seg;
                  next_s.lat_seg = seg;
                  next_s.f_seg = cmd_bit(in_cmd, CMD_SEG);
                  if (first) begin
                     // Options only from first descriptor of a packet
                     next_s.lat_l4 = in_opt[OPT_L4];
                     next_s.lat_l3 = in_opt[OPT_L3];
                     next_s.lat_ts = in_ext[EXT_STAMP];
                  end
                  if ((first && seg) || (cmd_bit(in_cmd, CMD_LAST) && !seg)) begin
                     next_s.lat_tag = cmd_bit(in_cmd, CMD_TAG);
                     next_s.lat_crc = cmd_bit(in_cmd, CMD_CRC);
                     next_s.lat_vtag = in_vtag;
                  end
                  next_s.in_pkt = !cmd_bit(in_cmd, CMD_LAST);
                  // Delay timer reloads on every delayed report
                  if (cmd_bit(in_cmd, CMD_DELAY) && cmd_bit(in_cmd, CMD_REPORT)) begin
                     next_s.t_load = 1'b1;
                  end
                  if (desc_addr_i != '0 && in_len != '0) begin
                     next_s.f_req = 1'b1;
                     next_s.f_addr = desc_addr_i;
                     next_s.f_len = in_len;
                     next_s.state = ST_FETCH;
                  end else begin
                     // Null buffer: skip the fetch
                     next_s.state = ST_FINISH;
                  end
               end else if (cmd_bit(in_cmd, CMD_EXTF) && in_type == TYPE_CTX) begin
                  next_s.ctx = 1'b1;
               end else begin
                  next_s.bad = 1'b1;
               end
            end
         end
         ST_FETCH: begin
            // Hold request until the data mover finishes
            if (fetch_done_i) begin
               next_s.f_req = 1'b0;
               next_s.state = ST_FINISH;
            end
         end
         ST_FINISH: begin
            // Packet attributes at its last descriptor
            if (cmd_bit(s.cmd, CMD_LAST)) begin
               next_s.p_done = 1'b1;
               next_s.p_tag = s.lat_tag;
               next_s.p_crc = s.lat_tag || s.lat_crc;
               next_s.p_etype = s.lat_tag ? tag_ethertype_register_i : 16'h0000;
               next_s.p_vtag = s.lat_tag ? s.lat_vtag : 16'h0000;
               next_s.p_l4 = s.lat_l4;
               next_s.p_l3 = s.lat_l3;
               next_s.p_ts = s.lat_ts;
               next_s.p_seg = s.lat_seg;
            end
            if (cmd_bit(s.cmd, CMD_REPORT)) begin
               next_s.wb_status = {STATUS_RSV, 1'b1};
               // Bursting holds delayed write-backs for the timer
               next_s.wb_req = !(wb_burst_en_i && cmd_bit(s.cmd, CMD_DELAY));
               next_s.state = ST_WRBK;
            end else begin
               next_s.ready = 1'b1;
               next_s.state = ST_IDLE;
            end
         end
         ST_WRBK: begin
            if (!s.wb_req) begin
               // Held write-back released by expiry or burst off
               if (tif.expire || !wb_burst_en_i) begin
                  next_s.wb_req = 1'b1;
               end
            end else if (wb_ack_i) begin
               next_s.wb_req = 1'b0;
               if (!cmd_bit(s.cmd, CMD_DELAY)) begin
                  next_s.irq = 1'b1;
                  next_s.t_clear = 1'b1;
               end
               next_s.ready = 1'b1;
               next_s.state = ST_IDLE;
            end
         end
         default: begin
            next_s.state = ST_IDLE;
            next_s.ready = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt delay timer
   assign tif.load = s.t_load;
   assign tif.clear = s.t_clear;
   assign tif.value = delay_value_field_i;

   irq_delay_timer #(
      .W(DW),
      .TICK_CYC(TICK_CYC)
   ) u_timer (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .tif(tif)
   );

   ////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign desc_ready_o = s.ready;
   assign fetch_req_o = s.f_req;
   assign fetch_addr_o = s.f_addr;
   assign fetch_len_o = s.f_len;
   assign fetch_seg_o = s.f_seg;
   assign wb_req_o = s.wb_req;
   assign wb_status_o = s.wb_status;
   assign tx_irq_o = s.irq;
   assign pkt_done_o = s.p_done;
   assign pkt_tag_insert_o = s.p_tag;
   assign pkt_crc_append_o = s.p_crc;
   assign pkt_tag_ethertype_o = s.p_etype;
   // Tag field split
   assign pkt_priority_field_o = s.p_vtag[TAG_PRI_LSB +: 3];
   assign pkt_canonical_format_flag_o = s.p_vtag[TAG_CFI];
   assign pkt_tag_id_o = s.p_vtag[TAG_ID_W-1:0];
   assign pkt_l4_checksum_insert_o = s.p_l4;
   assign pkt_l3_checksum_insert_o = s.p_l3;
   assign pkt_capture_transmit_time_o = s.p_ts;
   assign pkt_segmented_o = s.p_seg;
   assign ctx_desc_o = s.ctx;
   assign bad_desc_o = s.bad;
endmodule

// ==== tb/tx_desc_assertions.sv ====
// Port-level checker for the descriptor decoder
`timescale 1ns/1ns
module tx_desc_assertions
   import tx_desc_pkg::*;
#(
   parameter int DW = 16,
   parameter int TICK_CYC = 2
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic desc_valid_i,
   input wire logic [63:0] desc_addr_i,
   input wire logic [63:0] desc_info_i,
   input wire logic desc_ready_o,
   input wire logic fetch_req_o,
   input wire logic [63:0] fetch_addr_o,
   input wire logic [LEN_W-1:0] fetch_len_o,
   input wire logic fetch_seg_o,
   input wire logic fetch_done_i,
   input wire logic wb_req_o,
   input wire logic [3:0] wb_status_o,
   input wire logic wb_ack_i,
   input wire logic tx_irq_o,
   input wire logic pkt_done_o,
   input wire logic pkt_tag_insert_o,
   input wire logic pkt_crc_append_o,
   input wire logic ctx_desc_o,
   input wire logic bad_desc_o
);
   logic acc; // Descriptor taken this edge
   logic dat; // Extended data descriptor offered
   logic nul; // Null address or length
   assign acc = desc_valid_i && desc_ready_o;
   assign dat = desc_info_i[29] && desc_info_i[23:20] == TYPE_DATA;
   assign nul = desc_addr_i == 64'h0 || desc_info_i[19:0] == 20'h0;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   ////////////////////////////////////////////////////////////////
   a_data_fetch: assert property (acc && dat && !nul |=> fetch_req_o && fetch_addr_o == $past(desc_addr_i)
      && fetch_len_o == $past(desc_info_i[19:0]) && fetch_seg_o == $past(desc_info_i[26]))
      else $error("data descriptor fetch wrong");
   a_null_skip: assert property (acc && dat && nul |=> !fetch_req_o) else $error("null descriptor fetched");
   a_ctx_seen: assert property (acc && desc_info_i[29] && desc_info_i[23:20] == TYPE_CTX |=> ctx_desc_o && !fetch_req_o)
      else $error("context descriptor missed");
   a_bad_seen: assert property (acc && !desc_info_i[29] |=> bad_desc_o && !fetch_req_o)
      else $error("non-extended descriptor taken");
   a_fetch_hold: assert property (fetch_req_o && !fetch_done_i |=> fetch_req_o && $stable(fetch_addr_o)
      && $stable(fetch_len_o)) else $error("fetch request dropped");
   a_wb_after_fetch: assert property (wb_req_o |-> !fetch_req_o) else $error("write-back before fetch end");
   a_wb_status: assert property (wb_req_o |-> wb_status_o == {STATUS_RSV, 1'b1}) else $error("status bad");
   a_wb_end: assert property (wb_req_o && wb_ack_i |=> !wb_req_o) else $error("write-back held after ack");
   a_tag_crc: assert property (pkt_done_o && pkt_tag_insert_o |-> pkt_crc_append_o) else $error("tag without crc");
   // Main scenarios
   c_ctx: cover property (ctx_desc_o);
   c_irq: cover property (tx_irq_o);
   c_tag: cover property (pkt_done_o && pkt_tag_insert_o);
endmodule
bind tx_data_descriptor_decoder tx_desc_assertions #(.DW(DW), .TICK_CYC(TICK_CYC)) chk_inst (.clk_i(clk_i),
   .rst_b_i(rst_b_i), .desc_valid_i(desc_valid_i), .desc_addr_i(desc_addr_i), .desc_info_i(desc_info_i),
   .desc_ready_o(desc_ready_o), .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o), .fetch_len_o(fetch_len_o),
   .fetch_seg_o(fetch_seg_o), .fetch_done_i(fetch_done_i), .wb_req_o(wb_req_o), .wb_status_o(wb_status_o),
   .wb_ack_i(wb_ack_i), .tx_irq_o(tx_irq_o), .pkt_done_o(pkt_done_o), .pkt_tag_insert_o(pkt_tag_insert_o),
   .pkt_crc_append_o(pkt_crc_append_o), .ctx_desc_o(ctx_desc_o), .bad_desc_o(bad_desc_o));

// ==== tb/mem_model.sv ====
// Host memory stand-in answering fetch and write-back requests
`timescale 1ns/1ns
module mem_model (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic slow_i,
   input wire logic fetch_req_i,
   input wire logic wb_req_i,
   output logic fetch_done_o,
   output logic wb_ack_o
);
   logic [3:0] fc; // Fetch wait count
   logic [3:0] wc; // Write-back wait count
   logic [3:0] lat; // Answer latency
   assign lat = slow_i ? 4'h6 : 4'h1;
   ////////////////////////////////////////////////////////////////
   // Answer a request after the latency with a one-cycle pulse, then count again while it stays up
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         fc <= 4'h0;
         wc <= 4'h0;
         fetch_done_o <= 1'b0;
         wb_ack_o <= 1'b0;
      end else begin
         fetch_done_o <= fetch_req_i && !fetch_done_o && fc == lat;
         fc <= (fetch_req_i && !fetch_done_o) ? fc + 4'h1 : 4'h0;
         wb_ack_o <= wb_req_i && !wb_ack_o && wc == lat;
         wc <= (wb_req_i && !wb_ack_o) ? wc + 4'h1 : 4'h0;
      end
   end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the descriptor decoder
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module testbench;
   import tx_desc_pkg::*;
   localparam logic [15:0] ET = 16'h5A5A; // Tag ethertype value
   logic clk = 1'b0, rst_b = 1'b0, valid = 1'b0, burst = 1'b0, cause = 1'b1, slow = 1'b0;
   logic [63:0] addr = 64'h0, info = 64'h0, faddr;
   logic [15:0] dval = 16'd20, pet;
   logic [19:0] flen;
   logic [11:0] pid;
   logic [3:0] wst;
   logic [2:0] ppri;
   logic ready, freq, fseg, fdone, wreq, wack, irq, pd, pti, pca, pcfi, pl4, pl3, pts, pseg, ctx, bad;
   logic [37:0] pkv; // Packet fields as one vector
   logic [63:0] ri[8]; // Row descriptors
   logic [5:0] rx[8]; // Row counts: fetch, wb, packet, ctx, bad, irq
   int miscompares = 0, check_count = 0, nf, nw, np, nc, nb, ni;
   assign pkv = {pti, pca, pet, ppri, pcfi, pid, pl4, pl3, pts, pseg};
   initial forever #2 clk = ~clk;
   tx_data_descriptor_decoder #(.DW(16), .TICK_CYC(2)) tx_data_descriptor_decoder_inst (.clk_i(clk), .rst_b_i(rst_b),
      .desc_valid_i(valid), .desc_addr_i(addr), .desc_info_i(info), .desc_ready_o(ready), .fetch_req_o(freq),
      .fetch_addr_o(faddr), .fetch_len_o(flen), .fetch_seg_o(fseg), .fetch_done_i(fdone), .wb_req_o(wreq),
      .wb_status_o(wst), .wb_ack_i(wack), .wb_burst_en_i(burst), .delay_value_field_i(dval),
      .writeback_irq_cause_i(cause), .tag_ethertype_register_i(ET), .tx_irq_o(irq), .pkt_done_o(pd),
      .pkt_tag_insert_o(pti), .pkt_crc_append_o(pca), .pkt_tag_ethertype_o(pet), .pkt_priority_field_o(ppri),
      .pkt_canonical_format_flag_o(pcfi), .pkt_tag_id_o(pid), .pkt_l4_checksum_insert_o(pl4),
      .pkt_l3_checksum_insert_o(pl3), .pkt_capture_transmit_time_o(pts), .pkt_segmented_o(pseg),
      .ctx_desc_o(ctx), .bad_desc_o(bad));
   mem_model mem_model_inst (.clk_i(clk), .rst_b_i(rst_b), .slow_i(slow), .fetch_req_i(freq), .wb_req_i(wreq),
      .fetch_done_o(fdone), .wb_ack_o(wack));
   ////////////////////////////////////////////////////////////////
   // Count completed transfers and pulses
   always @(posedge clk) begin
      if (freq && fdone) nf++;
      if (wreq && wack) nw++;
      if (pd) np++;
      if (ctx) nc++;
      if (bad) nb++;
      if (irq) ni++;
   end
   // Second word from its fields
   function automatic logic [63:0] mk(input logic [7:0] c, input logic [19:0] l, input logic [15:0] g,
      input logic [7:0] o, input logic [3:0] x, input logic [3:0] t = 4'h1);
      mk = {g, o, x, 4'h0, c, t, l};
   endfunction
   // Expected packet fields of a one-descriptor packet
   function automatic logic [37:0] expf(input logic [63:0] i);
      expf = {i[30], i[30] | i[25], i[30] ? ET : 16'h0, i[30] ? i[63:48] : 16'h0, i[41], i[40], i[36], i[26]};
   endfunction
   task automatic clr();
      {nf, nw, np, nc, nb, ni} = '0;
   endtask
   // Wait at falling edges until the decoder is ready again
   task automatic wait_ready();
      int n;
      n = 0;
      @(negedge clk);
      while (ready !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (n >= 300) miscompares++;
   endtask
   // Offer one descriptor once ready is up, hold it over the taking edge
   task automatic send(input logic [63:0] a, input logic [63:0] i);
      wait_ready();
      @(posedge clk);
      valid <= 1'b1;
      addr <= a;
      info <= i;
      @(posedge clk);
      valid <= 1'b0;
   endtask
   // Let the current descriptor finish and its pulses be counted, offering nothing
   task automatic idle();
      wait_ready();
      repeat (3) @(negedge clk);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #40000;
      miscompares++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////
   // Main sequence: table rows, then packets, delay and bursting
   initial begin
      ri[0] = mk(8'h3B, 20'd64, 16'h0, 8'h02, 4'h1);
      ri[1] = mk(8'h29, 20'd16, 16'h0, 8'h0, 4'h0);
      ri[2] = mk(8'h21, 20'd0, 16'h0, 8'h0, 4'h0);
      ri[3] = mk(8'h20, 20'd0, 16'h0, 8'h0, 4'h0, 4'h0);
      ri[4] = mk(8'h01, 20'd8, 16'h0, 8'h0, 4'h0);
      ri[5] = mk(8'h20, 20'd8, 16'h0, 8'h0, 4'h0, 4'h2);
      // Tagged rows stand for software that also set the global tag mode
      ri[6] = mk(8'h61, 20'd32, 16'hA123, 8'hFC, 4'h0);
      ri[7] = mk(8'h23, 20'd4, 16'hBEEF, 8'h01, 4'h0);
      rx = '{6'b111001, 6'b011001, 6'b001000, 6'b000100, 6'b000010, 6'b000010, 6'b101000, 6'b101000};
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(negedge clk);
      `CHK("ready after reset", 1'b1, ready)
      for (int k = 0; k < 8; k++) begin
         slow <= k[0];
         clr();
         send((k == 1) ? 64'h0 : 64'(k + 1) << 12, ri[k]);
         idle();
         `CHK("counts", rx[k], {nf[0], nw[0], np[0], nc[0], nb[0], ni[0]})
         if (rx[k][3]) `CHK("fields", expf(ri[k]), pkv)
      end
      clr();
      send(64'h8000, mk(8'h60, 20'd40, 16'h0FFF, 8'h03, 4'h1));
      send(64'h9000, mk(8'h23, 20'd8, 16'h0, 8'h0, 4'h0));
      idle();
      `CHK("one packet", 2'd1, np[1:0])
      `CHK("plain fields", {2'b01, 32'h0, 4'b1110}, pkv)
      send(64'hA000, mk(8'h66, 20'd54, 16'h7005, 8'h03, 4'h0));
      send(64'hB000, mk(8'h27, 20'd100, 16'h0, 8'h0, 4'h0));
      idle();
      `CHK("seg fields", {2'b11, ET, 16'h7005, 4'b1101}, pkv)
      clr();
      send(64'hC000, mk(8'hA9, 20'd8, 16'h0, 8'h0, 4'h0));
      idle();
      `CHK("prompt wb", 2'b10, {nw[0], ni[0]})
      repeat (50) @(negedge clk);
      `CHK("delayed irq", 2'd1, ni[1:0])
      clr();
      send(64'hC000, mk(8'hA9, 20'd8, 16'h0, 8'h0, 4'h0));
      repeat (20) @(negedge clk);
      send(64'hC100, mk(8'hA9, 20'd8, 16'h0, 8'h0, 4'h0));
      repeat (28) @(negedge clk);
      `CHK("reloaded", 2'd0, ni[1:0])
      repeat (25) @(negedge clk);
      `CHK("reload irq", 2'd1, ni[1:0])
      clr();
      send(64'hC000, mk(8'hA9, 20'd8, 16'h0, 8'h0, 4'h0));
      send(64'hD000, mk(8'h29, 20'd8, 16'h0, 8'h0, 4'h0));
      idle();
      repeat (50) @(negedge clk);
      `CHK("timer cleared", 2'd1, ni[1:0])
      @(posedge clk);
      cause <= 1'b0;
      clr();
      send(64'hC000, mk(8'hA9, 20'd8, 16'h0, 8'h0, 4'h0));
      repeat (60) @(negedge clk);
      `CHK("cause off", 2'd0, ni[1:0])
      @(posedge clk);
      burst <= 1'b1;
      clr();
      send(64'hE000, mk(8'hA9, 20'd8, 16'h0, 8'h0, 4'h0));
      repeat (20) @(negedge clk);
      `CHK("burst held", 2'd0, nw[1:0])
      repeat (40) @(negedge clk);
      `CHK("burst wb", 2'd1, nw[1:0])
      // Reset in mid-fetch drops every request, then ready comes back
      send(64'hF000, mk(8'h21, 20'd8, 16'h0, 8'h0, 4'h0));
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("mid reset", 5'h00, {ready, freq, wreq, irq, pd})
      rst_b <= 1'b1;
      repeat (2) @(negedge clk);
      `CHK("ready after mid reset", 1'b1, ready)
      clr();
      send(64'hF100, mk(8'h29, 20'd8, 16'h0, 8'h0, 4'h0));
      idle();
      `CHK("after reset", 4'hF, {nf[0], nw[0], np[0], ni[0]})
      final_report();
   end
endmodule
